// File: include/pgs_defs.vh
// pgs_defs.vh: register indices, field positions, reset values and
// fixed patterns of the per-port gigabit status / mmd / loopback group.
// assumes: included once per design file by bare name; definitions only.
`ifndef PGS_DEFS_VH
`define PGS_DEFS_VH

// register indices; byte address = 4 * index, port digit in index[13:12]
`define PGS_IDX_GIG_STAT   12'h114
`define PGS_IDX_MMD_INDIRECT_SETUP  12'h11A
`define PGS_IDX_MMD_INDIRECT_DATA   12'h11C
`define PGS_IDX_EXT_STAT   12'h11E
`define PGS_IDX_LOOPBACK   12'h122

// port digits in the index
`define PGS_PORT_DIGIT_1   2'h1
`define PGS_PORT_DIGIT_2   2'h2

// gigabit link status fields
`define PGS_GS_FAULT_BIT   15
`define PGS_GS_MASTER_BIT  14
`define PGS_GS_LRX_BIT     13
`define PGS_GS_RRX_BIT     12
`define PGS_GS_LPFD_BIT    11
`define PGS_GS_LPHD_BIT    10
`define PGS_GS_CNT_W       8

// mmd_indirect_setup fields and operation codes
`define PGS_MMD_OP_HI      15
`define PGS_MMD_OP_LO      14
`define PGS_MMD_DEV_HI     4
`define PGS_MMD_DEV_LO     0
`define PGS_MMD_OP_INDEX   2'h0
`define PGS_MMD_OP_DATA    2'h1
`define PGS_MMD_OP_INC_RW  2'h2
`define PGS_MMD_OP_INC_WR  2'h3
`define PGS_MMD_INDIRECT_SETUP_RST  16'h0000
`define PGS_MMD_INDIRECT_DATA_RST   16'h0000

// extended ability status: 1000x fd/hd = 0, 1000t fd/hd = 1
`define PGS_EXT_STAT_VAL   16'h3000

// line loopback control
`define PGS_LB_EN_BIT      8
`define PGS_LB_RC_BIT      1
`define PGS_LB_RO_BIT      0
`define PGS_LB_RST         16'h00F4

`endif

// File: src/pgs_mmd_port.v
// pgs_mmd_port.v: one port's indirect window onto the mmd devices:
// setup register, per-device register index, access strobes.
// assumes: the mmd store answers mmd_rdata_i combinationally for the
// device and index on mmd_dev_o / mmd_idx_o; strobes are one cycle.
`include "pgs_defs.vh"
`default_nettype none

module pgs_mmd_port #(
   parameter DEVS = 32
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        setup_wr_i,
   input  wire [15:0] setup_d_i,
   input  wire        data_wr_i,
   input  wire [15:0] data_d_i,
   input  wire        data_rd_i,
   input  wire [15:0] mmd_rdata_i,
   output wire [15:0] setup_o,
   output reg  [15:0] data_view_o,
   output reg         mmd_wr_o,
   output reg         mmd_rd_o,
   output wire [4:0]  mmd_dev_o,
   output wire [15:0] mmd_idx_o,
   output reg  [15:0] mmd_wdata_o
);

   reg  [15:0] setup_reg;
   reg  [15:0] idx_reg [0:DEVS-1];   // one register index per device
   wire [1:0]  op;
   wire [4:0]  dev;
   wire        is_data;
   wire        inc;
   reg         inc_pend;         // advance index one cycle after commit
   integer     i;

   assign setup_o   = setup_reg;
   // (RULE_07) operation select
   assign op        = setup_reg[`PGS_MMD_OP_HI:`PGS_MMD_OP_LO];
   // (RULE_08) target device address
   assign dev       = setup_reg[`PGS_MMD_DEV_HI:`PGS_MMD_DEV_LO];
   assign is_data   = (op != `PGS_MMD_OP_INDEX);
   assign mmd_dev_o = dev;
   assign mmd_idx_o = idx_reg[dev];

   // (RULE_09) index view or (RULE_10) data view
   always @* begin
      data_view_o = is_data ? mmd_rdata_i : idx_reg[dev];
   end

   // (RULE_11) post increment: 10 on both, 11 on writes, 01 never
   assign inc = (op == `PGS_MMD_OP_INC_RW && (data_wr_i || data_rd_i)) ||
                (op == `PGS_MMD_OP_INC_WR && data_wr_i);

   // setup, index store and registered strobes toward the mmd store
   always @(posedge clk_i) begin
      if (rst_i) begin
         setup_reg   <= `PGS_MMD_INDIRECT_SETUP_RST;
         mmd_wr_o    <= 1'b0;
         mmd_rd_o    <= 1'b0;
         mmd_wdata_o <= `PGS_MMD_INDIRECT_DATA_RST;
         inc_pend    <= 1'b0;
         for (i = 0; i < DEVS; i = i + 1) begin
            idx_reg[i] <= `PGS_MMD_INDIRECT_DATA_RST;
         end
      end else begin
         mmd_wr_o <= data_wr_i & is_data;
         mmd_rd_o <= data_rd_i & is_data;
         inc_pend <= inc;
         if (setup_wr_i) begin
            setup_reg <= setup_d_i;
         end
         if (data_wr_i && is_data) begin
            mmd_wdata_o <= data_d_i;
         end
         // (RULE_09) index written in register mode
         if (data_wr_i && !is_data) begin
            idx_reg[dev] <= data_d_i;
         // (RULE_11) advance while the strobe stands, so the store sees
         // the pre-increment index together with mmd_wr_o / mmd_rd_o
         end else if (inc_pend) begin
            idx_reg[dev] <= idx_reg[dev] + 16'h0001;
         end
      end
   end

endmodule // pgs_mmd_port

`default_nettype wire

// File: src/pgs_port_regs.v
// pgs_port_regs.v: two-port gigabit status, mmd window and line loopback
// register group behind a classic wishbone slave.
// assumes: status and data inputs come from phy logic on clk_i; the
// mmd register contents live outside and answer combinationally.
//
// Function
// (RULE_01) fault flag bit 15 latches high until cleared by a read.
// (RULE_02) bit 14 shows master/slave resolution: 1 master, 0 slave.
// (RULE_03) bit 13 is live local receiver ok status, not latched.
// (RULE_04) bit 12 is live remote receiver ok status.
// (RULE_05) bits 11 and 10 show partner 1000t full and half duplex ability.
// (RULE_06) bits 7:0 count qualified idle symbol errors, cleared by read.
// (RULE_07) setup bits 15:14 pick index, data, inc-rw or inc-write mode.
// (RULE_08) setup bits 4:0 hold the target mmd device address.
// (RULE_09) in mode 00 the data register accesses the register index.
// (RULE_10) otherwise the data register moves the indexed register's value.
// (RULE_11) mode 11 advances index after writes only; mode 01 never.
// (RULE_12) extended status bits 15 and 14 read fixed 0.
// (RULE_13) extended status bits 13 and 12 read fixed 1.
// (RULE_14) loopback bit 8 returns line receive data to line transmit.
// (RULE_15) each port has its own copy at port-numbered base.
// (RULE_16) software writes reserved fields back with reset values.
`include "pgs_defs.vh"
`default_nettype none

module pgs_port_regs #(
   parameter DW       = 8,
   parameter MMD_DEVS = 32
) (
   input  wire            clk_i,
   input  wire            rst_i,
   // wishbone classic slave
   input  wire            wb_cyc_i,
   input  wire            wb_stb_i,
   input  wire            wb_we_i,
   input  wire [15:2]     wb_adr_i,
   input  wire [3:0]      wb_sel_i,
   input  wire [31:0]     wb_dat_i,
   output reg  [31:0]     wb_dat_o,
   output reg             wb_ack_o,
   // phy status, one bit per port
   input  wire [1:0]      ms_fault_i,
   input  wire [1:0]      ms_master_i,
   input  wire [1:0]      local_rx_ok_i,
   input  wire [1:0]      remote_rx_ok_i,
   input  wire [1:0]      lp_1000_fd_i,
   input  wire [1:0]      lp_1000_hd_i,
   input  wire [1:0]      sym_tick_i,
   input  wire [1:0]      rx_err_i,
   input  wire [1:0]      rx_idle_i,
   input  wire [1:0]      tx_send_n_i,
   // mmd store access, port 1 in low slice
   output wire [1:0]      mmd_wr_o,
   output wire [1:0]      mmd_rd_o,
   output wire [9:0]      mmd_dev_o,
   output wire [31:0]     mmd_idx_o,
   output wire [31:0]     mmd_wdata_o,
   input  wire [31:0]     mmd_rdata_i,
   // line / fabric data paths, port 1 in low slice
   input  wire [2*DW-1:0] line_rx_d_i,
   input  wire [1:0]      line_rx_v_i,
   input  wire [2*DW-1:0] fab_tx_d_i,
   input  wire [1:0]      fab_tx_v_i,
   output reg  [2*DW-1:0] line_tx_d_o,
   output reg  [1:0]      line_tx_v_o,
   output reg  [2*DW-1:0] fab_rx_d_o,
   output reg  [1:0]      fab_rx_v_o,
   output wire [1:0]      loopback_o
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // merge 16-bit write data into an old value under the low byte lanes
   function [15:0] merge16;
      input [15:0] old_v;
      input [15:0] new_v;
      input [1:0]  sel;
      begin
         merge16[7:0]  = sel[0] ? new_v[7:0]  : old_v[7:0];
         merge16[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
      end
   endfunction

   // register index within a port, matched against the low twelve bits
   function hit_reg;
      input [13:0] adr;
      input [11:0] idx;
      begin
         hit_reg = (adr[11:0] == idx);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus handshake

   wire        req;
   wire        capture;          // edge at which ack rises
   wire        commit;           // edge at which master samples ack
   wire        wr_commit;
   wire        rd_commit;
   wire [1:0]  port_hit;
   wire        sel_gs;
   wire        sel_set;
   wire        sel_dat;
   wire        sel_ext;
   wire        sel_lb;
   reg         ack_next;

   assign req       = wb_cyc_i & wb_stb_i;
   assign capture   = req & ~wb_ack_o;
   assign commit    = req & wb_ack_o;
   assign wr_commit = commit & wb_we_i;
   assign rd_commit = commit & ~wb_we_i;

   // (RULE_15) port digit in index bits 13:12 picks the copy
   assign port_hit[0] = (wb_adr_i[15:14] == `PGS_PORT_DIGIT_1);
   assign port_hit[1] = (wb_adr_i[15:14] == `PGS_PORT_DIGIT_2);
   assign sel_gs  = hit_reg(wb_adr_i, `PGS_IDX_GIG_STAT);
   assign sel_set = hit_reg(wb_adr_i, `PGS_IDX_MMD_INDIRECT_SETUP);
   assign sel_dat = hit_reg(wb_adr_i, `PGS_IDX_MMD_INDIRECT_DATA);
   assign sel_ext = hit_reg(wb_adr_i, `PGS_IDX_EXT_STAT);
   assign sel_lb  = hit_reg(wb_adr_i, `PGS_IDX_LOOPBACK);

   // one wait state; unmapped addresses are acked and read zero
   always @* begin
      ack_next = capture;
   end

   ////////////////////////////////////////////////////////////////////////
   // per-port state

   wire [15:0] gs_view   [0:1];
   wire [15:0] set_view  [0:1];
   wire [15:0] dat_view  [0:1];
   wire [15:0] lb_view   [0:1];
   // snapshot of clear-on-read bits, taken when the read data is latched
   reg         snap_fault_reg;
   reg  [7:0]  snap_cnt_reg;
   reg         snap_lbrc_reg;

   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : g_port
         reg         fault_reg;
         reg         fault_next;
         reg  [7:0]  cnt_reg;
         reg  [7:0]  cnt_next;
         reg  [15:0] lb_reg;
         reg  [15:0] lb_next;
         wire        rd_gs;
         wire        rd_lb;
         wire        wr_lb;
         wire        err_hit;
         wire [15:0] dat_merge;

         assign rd_gs = rd_commit & port_hit[p] & sel_gs;
         assign rd_lb = rd_commit & port_hit[p] & sel_lb;
         assign wr_lb = wr_commit & port_hit[p] & sel_lb;

         // (RULE_06) one count per errored symbol during idles and send_n
         assign err_hit = sym_tick_i[p] & rx_err_i[p] & rx_idle_i[p] &
                          tx_send_n_i[p];

         // clear-on-read bits: only what was read is taken away, so an
         // event in the read cycle survives (set wins over clear)
         always @* begin
            // (RULE_01) latch high, clear only the value read
            fault_next = ms_fault_i[p] |
                         (fault_reg & ~(rd_gs & snap_fault_reg));
            // (RULE_06) subtract the value read, saturate at all ones
            cnt_next = rd_gs ? (cnt_reg - snap_cnt_reg) : cnt_reg;
            if (err_hit && cnt_next != 8'hFF) begin
               cnt_next = cnt_next + 8'h01;
            end
            // (RULE_16) reserved fields are stored as written
            lb_next = wr_lb ? merge16(lb_reg, wb_dat_i[15:0],
                                      wb_sel_i[1:0]) : lb_reg;
            if (rd_lb && snap_lbrc_reg && !wr_lb) begin
               lb_next[`PGS_LB_RC_BIT] = 1'b0;
            end
            lb_next[`PGS_LB_RO_BIT] = 1'b0;
         end

         always @(posedge clk_i) begin
            if (rst_i) begin
               fault_reg <= 1'b0;
               cnt_reg   <= 8'h00;
               lb_reg    <= `PGS_LB_RST;
            end else begin
               fault_reg <= fault_next;
               cnt_reg   <= cnt_next;
               lb_reg    <= lb_next;
            end
         end

         // (RULE_02) (RULE_03) (RULE_04) (RULE_05) live status fields
         assign gs_view[p] = {fault_reg, ms_master_i[p], local_rx_ok_i[p],
                              remote_rx_ok_i[p], lp_1000_fd_i[p],
                              lp_1000_hd_i[p], 2'b00, cnt_reg};
         assign lb_view[p] = lb_reg;
         // (RULE_14) loopback enable
         assign loopback_o[p] = lb_reg[`PGS_LB_EN_BIT];

         // data register writes merge under byte lanes against its view
         assign dat_merge = merge16(dat_view[p], wb_dat_i[15:0],
                                    wb_sel_i[1:0]);

         // (RULE_15) independent mmd window per port
         pgs_mmd_port #(
            .DEVS        (MMD_DEVS)
         ) u_mmd (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .setup_wr_i  (wr_commit & port_hit[p] & sel_set),
            .setup_d_i   (merge16(set_view[p], wb_dat_i[15:0],
                                  wb_sel_i[1:0])),
            .data_wr_i   (wr_commit & port_hit[p] & sel_dat),
            .data_d_i    (dat_merge),
            .data_rd_i   (rd_commit & port_hit[p] & sel_dat),
            .mmd_rdata_i (mmd_rdata_i[16*p+15:16*p]),
            .setup_o     (set_view[p]),
            .data_view_o (dat_view[p]),
            .mmd_wr_o    (mmd_wr_o[p]),
            .mmd_rd_o    (mmd_rd_o[p]),
            .mmd_dev_o   (mmd_dev_o[5*p+4:5*p]),
            .mmd_idx_o   (mmd_idx_o[16*p+15:16*p]),
            .mmd_wdata_o (mmd_wdata_o[16*p+15:16*p])
         );

         // (RULE_14) line data returned to line, fabric receive held off
         always @(posedge clk_i) begin
            if (rst_i) begin
               line_tx_d_o[DW*p+DW-1:DW*p] <= {DW{1'b0}};
               line_tx_v_o[p]              <= 1'b0;
               fab_rx_d_o[DW*p+DW-1:DW*p]  <= {DW{1'b0}};
               fab_rx_v_o[p]               <= 1'b0;
            end else if (lb_reg[`PGS_LB_EN_BIT]) begin
               line_tx_d_o[DW*p+DW-1:DW*p] <= line_rx_d_i[DW*p+DW-1:DW*p];
               line_tx_v_o[p]              <= line_rx_v_i[p];
               fab_rx_d_o[DW*p+DW-1:DW*p]  <= {DW{1'b0}};
               fab_rx_v_o[p]               <= 1'b0;
            end else begin
               line_tx_d_o[DW*p+DW-1:DW*p] <= fab_tx_d_i[DW*p+DW-1:DW*p];
               line_tx_v_o[p]              <= fab_tx_v_i[p];
               fab_rx_d_o[DW*p+DW-1:DW*p]  <= line_rx_d_i[DW*p+DW-1:DW*p];
               fab_rx_v_o[p]               <= line_rx_v_i[p];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // read data path

   reg  [15:0] rd_mux;
   reg         pidx;
   reg         pvalid;

   // select the addressed port copy and register
   always @* begin
      pidx   = port_hit[1];
      pvalid = port_hit[0] | port_hit[1];
      rd_mux = 16'h0000;
      if (pvalid) begin
         if (sel_gs) begin
            rd_mux = gs_view[pidx];
         end else if (sel_set) begin
            rd_mux = set_view[pidx];
         end else if (sel_dat) begin
            // (RULE_09) (RULE_10) index or indexed data
            rd_mux = dat_view[pidx];
         end else if (sel_ext) begin
            // (RULE_12) (RULE_13) fixed ability pattern
            rd_mux = `PGS_EXT_STAT_VAL;
         end else if (sel_lb) begin
            rd_mux = lb_view[pidx];
         end
      end
   end

   // latch read data and the clear-on-read snapshot as ack rises;
   // the clear itself happens at the edge the master takes the data
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o       <= 1'b0;
         wb_dat_o       <= 32'h00000000;
         snap_fault_reg <= 1'b0;
         snap_cnt_reg   <= 8'h00;
         snap_lbrc_reg  <= 1'b0;
      end else begin
         wb_ack_o <= ack_next;
         if (capture) begin
            wb_dat_o       <= {16'h0000, rd_mux};
            // (RULE_01) (RULE_06) remember what this read will clear
            snap_fault_reg <= rd_mux[`PGS_GS_FAULT_BIT];
            snap_cnt_reg   <= rd_mux[`PGS_GS_CNT_W-1:0];
            snap_lbrc_reg  <= rd_mux[`PGS_LB_RC_BIT];
         end
      end
   end

endmodule // pgs_port_regs

`default_nettype wire

// File: test/pgs_port_regs_props.sv
// pgs_port_regs_props.sv: assertions on the port register group's ports.
// assumes: single clock, synchronous active-high reset, port 1 watched.
`default_nettype none
module pgs_port_regs_props #(
   parameter DW = 8
) (
   input wire logic            clk_i,
   input wire logic            rst_i,
   input wire logic            wb_cyc_i,
   input wire logic            wb_stb_i,
   input wire logic            wb_we_i,
   input wire logic [15:2]     wb_adr_i,
   input wire logic [31:0]     wb_dat_o,
   input wire logic            wb_ack_o,
   input wire logic [1:0]      ms_fault_i,
   input wire logic [1:0]      ms_master_i,
   input wire logic [1:0]      local_rx_ok_i,
   input wire logic [1:0]      remote_rx_ok_i,
   input wire logic [1:0]      lp_1000_fd_i,
   input wire logic [1:0]      lp_1000_hd_i,
   input wire logic [2*DW-1:0] line_rx_d_i,
   input wire logic [1:0]      line_rx_v_i,
   input wire logic [2*DW-1:0] fab_tx_d_i,
   input wire logic [2*DW-1:0] line_tx_d_o,
   input wire logic [1:0]      fab_rx_v_o,
   input wire logic [1:0]      loopback_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   // read answers; data was latched as ack rose, from inputs of the cycle before ack
   logic rd_ack;
   assign rd_ack = wb_ack_o && !wb_we_i;
   chk_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack missing after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_fault_held: assert property (
      rd_ack && wb_adr_i == 14'h1114 && $past(ms_fault_i[0], 3)
      |-> wb_dat_o[15]) else $error("fault flag lost");
   chk_live_status: assert property (
      rd_ack && wb_adr_i == 14'h1114 |-> wb_dat_o[14:10] ==
      $past({ms_master_i[0], local_rx_ok_i[0], remote_rx_ok_i[0],
      lp_1000_fd_i[0], lp_1000_hd_i[0]})) else $error("status bits wrong");
   chk_ext_fixed: assert property (
      rd_ack && wb_adr_i[13:2] == 12'h11E && (wb_adr_i[15:14] == 2'h1 ||
      wb_adr_i[15:14] == 2'h2) |-> wb_dat_o == 32'h0000_3000)
      else $error("extended status not fixed");
   chk_loop_view: assert property (
      rd_ack && wb_adr_i == 14'h1122 |-> wb_dat_o[8] == loopback_o[0])
      else $error("loopback output differs from register");
   ////////////////////////////////////////////////////////////////////////
   // data path, one cycle of latency
   chk_loop_tx: assert property (
      loopback_o[0] ##1 loopback_o[0] |-> !fab_rx_v_o[0] &&
      line_tx_d_o[DW-1:0] == $past(line_rx_d_i[DW-1:0]))
      else $error("looped data wrong");
   chk_normal_tx: assert property (
      !loopback_o[0] ##1 !loopback_o[0] |-> fab_rx_v_o[0] ==
      $past(line_rx_v_i[0]) && line_tx_d_o[DW-1:0] ==
      $past(fab_tx_d_i[DW-1:0])) else $error("normal data path wrong");
endmodule // pgs_port_regs_props
bind pgs_port_regs pgs_port_regs_props #(.DW(DW)) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .ms_fault_i(ms_fault_i), .ms_master_i(ms_master_i),
   .local_rx_ok_i(local_rx_ok_i), .remote_rx_ok_i(remote_rx_ok_i),
   .lp_1000_fd_i(lp_1000_fd_i), .lp_1000_hd_i(lp_1000_hd_i),
   .line_rx_d_i(line_rx_d_i), .line_rx_v_i(line_rx_v_i),
   .fab_tx_d_i(fab_tx_d_i), .line_tx_d_o(line_tx_d_o),
   .fab_rx_v_o(fab_rx_v_o), .loopback_o(loopback_o));
`default_nettype wire

// File: test/pgs_port_regs_tb.sv
// pgs_port_regs_tb.sv: self-checking bench for the port register group.
// assumes: wishbone ack one cycle after a request, 100 MHz clock.
`default_nettype none
module pgs_port_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [15:2] wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, mmd_idx_o, mmd_wdata_o, mmd_rdata_i;
   logic [1:0]  ms_fault_i, ms_master_i, local_rx_ok_i, remote_rx_ok_i;
   logic [1:0]  lp_1000_fd_i, lp_1000_hd_i, sym_tick_i, rx_err_i;
   logic [1:0]  rx_idle_i, tx_send_n_i, mmd_wr_o, mmd_rd_o, line_rx_v_i;
   logic [1:0]  fab_tx_v_i, line_tx_v_o, fab_rx_v_o, loopback_o;
   logic [9:0]  mmd_dev_o;
   logic [15:0] line_rx_d_i, fab_tx_d_i, line_tx_d_o, fab_rx_d_o, rd;
   int          fails, checked, cycles;
   pgs_port_regs #(.DW(8), .MMD_DEVS(32)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ms_fault_i(ms_fault_i),
      .ms_master_i(ms_master_i), .local_rx_ok_i(local_rx_ok_i),
      .remote_rx_ok_i(remote_rx_ok_i), .lp_1000_fd_i(lp_1000_fd_i),
      .lp_1000_hd_i(lp_1000_hd_i), .sym_tick_i(sym_tick_i),
      .rx_err_i(rx_err_i), .rx_idle_i(rx_idle_i),
      .tx_send_n_i(tx_send_n_i), .mmd_wr_o(mmd_wr_o), .mmd_rd_o(mmd_rd_o),
      .mmd_dev_o(mmd_dev_o), .mmd_idx_o(mmd_idx_o),
      .mmd_wdata_o(mmd_wdata_o), .mmd_rdata_i(mmd_rdata_i),
      .line_rx_d_i(line_rx_d_i), .line_rx_v_i(line_rx_v_i),
      .fab_tx_d_i(fab_tx_d_i), .fab_tx_v_i(fab_tx_v_i),
      .line_tx_d_o(line_tx_d_o), .line_tx_v_o(line_tx_v_o),
      .fab_rx_d_o(fab_rx_d_o), .fab_rx_v_o(fab_rx_v_o),
      .loopback_o(loopback_o));
   ////////////////////////////////////////////////////////////////////////
   // comparison, verdict and one wishbone classic cycle
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // request held until ack is sampled; a hang is cut by the cycle limit
   task wb_cycle(input logic we, input logic [15:2] a, input logic [15:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'h3;
      wb_dat_i <= {16'h0000, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd = wb_dat_o[15:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task rd_chk(input logic [15:2] a, input logic [31:0] exp);
      wb_cycle(1'b0, a, 16'h0000);
      check({16'h0000, rd}, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_reset;
      for (int p = 1; p <= 2; p++) begin
         rd_chk({p[1:0], 12'h11A}, 32'h0000_0000);
         rd_chk({p[1:0], 12'h11C}, 32'h0000_0000);
         wb_cycle(1'b1, {p[1:0], 12'h11E}, 16'hFFFF);
         rd_chk({p[1:0], 12'h11E}, 32'h0000_3000);
         rd_chk({p[1:0], 12'h122}, 32'h0000_00F4);
      end
      rd_chk(14'h3114, 32'h0000_0000);
   endtask
   task t_status;
      {ms_master_i, local_rx_ok_i, remote_rx_ok_i} <= 6'h19;
      {lp_1000_fd_i, lp_1000_hd_i, ms_fault_i} <= 6'h19;
      @(posedge clk_i);
      ms_fault_i <= 2'h0;
      rd_chk(14'h1114, 32'h0000_D800);
      rd_chk(14'h1114, 32'h0000_5800);
      rd_chk(14'h2114, 32'h0000_2400);
      {ms_master_i, local_rx_ok_i, remote_rx_ok_i} <= 6'h26;
      {lp_1000_fd_i, lp_1000_hd_i} <= 4'h9;
      rd_chk(14'h1114, 32'h0000_2400);
   endtask
   // port 2 lacks the send qualifier, so only port 1 counts
   task t_count;
      {sym_tick_i, rx_err_i, rx_idle_i, tx_send_n_i} <= 8'hFD;
      repeat (5) @(posedge clk_i);
      rx_idle_i <= 2'h0;
      @(posedge clk_i);
      sym_tick_i <= 2'h0;
      rd_chk(14'h1114, 32'h0000_2405);
      rd_chk(14'h1114, 32'h0000_2400);
      rd_chk(14'h2114, 32'h0000_5800);
   endtask
   task idx_chk(input logic [15:0] exp);
      @(posedge clk_i);
      #1;
      check({16'h0000, mmd_idx_o[15:0]}, {16'h0000, exp});
   endtask
   task t_mmd;
      wb_cycle(1'b1, 14'h111A, 16'h0003);
      wb_cycle(1'b1, 14'h111C, 16'h0010);
      rd_chk(14'h111C, 32'h0000_0010);
      check(32'(mmd_dev_o[4:0]), 32'h0000_0003);
      wb_cycle(1'b1, 14'h111A, 16'h4003);
      rd_chk(14'h111C, 32'h0000_1234);
      wb_cycle(1'b1, 14'h111C, 16'hABCD);
      #1;
      check(32'({mmd_wr_o, mmd_wdata_o[15:0]}), 32'h0001_ABCD);
      idx_chk(16'h0010);
      wb_cycle(1'b1, 14'h111A, 16'hC003);
      rd_chk(14'h111C, 32'h0000_1234);
      idx_chk(16'h0010);
      wb_cycle(1'b1, 14'h111C, 16'h5555);
      #1;
      check(32'({mmd_wr_o, mmd_idx_o[15:0]}), 32'h0001_0010);
      idx_chk(16'h0011);
      wb_cycle(1'b1, 14'h111A, 16'h8003);
      rd_chk(14'h111C, 32'h0000_1234);
      #1;
      check(32'({mmd_rd_o, mmd_idx_o[15:0]}), 32'h0001_0011);
      idx_chk(16'h0012);
      rd_chk(14'h111A, 32'h0000_8003);
      wb_cycle(1'b1, 14'h111A, 16'h0003);
      rd_chk(14'h111C, 32'h0000_0012);
      wb_cycle(1'b1, 14'h111A, 16'h0004);
      rd_chk(14'h111C, 32'h0000_0000);
      rd_chk(14'h211A, 32'h0000_0000);
   endtask
   task t_loop;
      wb_cycle(1'b1, 14'h1122, 16'h01F4);
      rd_chk(14'h1122, 32'h0000_01F4);
      check(32'(loopback_o), 32'h0000_0001);
      line_rx_d_i <= 16'h3C5A;
      fab_tx_d_i <= 16'h9966;
      {line_rx_v_i, fab_tx_v_i} <= 4'hF;
      repeat (2) @(posedge clk_i);
      #1;
      check(32'({line_tx_v_o, line_tx_d_o}), 32'h0003_995A);
      check(32'({fab_rx_v_o, fab_rx_d_o[15:8]}), 32'h0000_023C);
      wb_cycle(1'b1, 14'h1122, 16'h00F4);
      repeat (2) @(posedge clk_i);
      #1;
      check(32'({line_tx_v_o, line_tx_d_o}), 32'h0003_9966);
      check(32'({fab_rx_v_o, fab_rx_d_o}), 32'h0003_3C5A);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // clock, reset, sequence and cycle limit
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {ms_fault_i, ms_master_i, local_rx_ok_i, remote_rx_ok_i} = '0;
      {lp_1000_fd_i, lp_1000_hd_i, sym_tick_i, rx_err_i} = '0;
      {rx_idle_i, tx_send_n_i, line_rx_v_i, fab_tx_v_i} = '0;
      {line_rx_d_i, fab_tx_d_i} = '0;
      mmd_rdata_i = 32'h7777_1234;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset;
      t_status;
      t_count;
      t_mmd;
      t_loop;
      complete_run;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         complete_run;
      end
   end
endmodule // pgs_port_regs_tb
`default_nettype wire
